// >>> src/qpw_top.sv
// Purpose: wiper, terminal switch and lock control of a quad digital pot
// Assumes: CMD_VALID marks a serial command that has just completed
// Notes:   switch and tap outputs follow the registers one cycle later
// Operation
// - pot 3 shutdown-force bit low forces network 3 into shutdown
// - upper register bits 6..4 connect pot 3 A, W, B when set
// - pot 2 shutdown-force bit low forces network 2 into shutdown
// - upper register bits 2..0 connect pot 2 A, W, B when set
// - terminal writes never change any wiper value
// - four independent networks, each with wiper, terminal bits and lock
// - 8-bit variant decodes 257 taps over 256 segments
// - 7-bit variant decodes 129 taps over 128 segments
// - volatile wiper closes exactly one tap switch
// - zero wiper joins W to B; decrement at zero ignored
// - full scale joins W to A; increment at full scale ignored
// - values above full scale also decode as full scale
// - reserved values above full scale ignore increment and decrement
// - four lock bits block wiper writes; only locks 2 and 3 block terminal bits (pots 0 and 1 use TCON_LO)
// - each lock covers its own network's wiper and, for pots 2 and 3, its terminal bits only
// - lock bits change only through high-voltage commands or reset, which loads LOCK_INIT
// - shutdown disconnects A and joins W to B
// - shutdown overrides connect bits without altering them
// - new terminal value reaches switches after command completes
// - reset loads terminal registers with all ones
`timescale 1ns/1ps
module qpw_top #(
	parameter int WIPER_BITS = 8,
	parameter int TAPS       = (1 << WIPER_BITS) + 1,
	parameter int WIPER_POR  = 1 << (WIPER_BITS - 1)
) (
	input  wire logic                                      REF_CLK,
	input  wire logic                                      RST,
	input  wire logic                                      CMD_VALID,
	input  wire logic [2:0]                                CMD_OP,
	input  wire logic [1:0]                                CMD_POT,
	input  wire logic [qpw_pkg::WIPER_W-1:0]               CMD_DATA,
	input  wire logic                                      HIGH_VOLTAGE_CMD_STROBE,
	input  wire logic [qpw_pkg::NPOT-1:0]                  LOCK_INIT,
	input  wire logic [qpw_pkg::TC_HI_W-1:0]               TCON_LO,
	output logic      [qpw_pkg::WIPER_W-1:0]               CMD_RDATA,
	output logic                                           CMD_REJECT,
	output logic                                           NV_WR_STB,
	output logic      [1:0]                                NV_WR_POT,
	output logic      [qpw_pkg::WIPER_W-1:0]               NV_WR_DATA,
	output logic      [qpw_pkg::NPOT-1:0]                  LOCK_STAT,
	output logic      [qpw_pkg::NPOT-1:0]                  END_A_CONNECT,
	output logic      [qpw_pkg::NPOT-1:0]                  WIPER_CONNECT,
	output logic      [qpw_pkg::NPOT-1:0]                  END_B_CONNECT,
	output logic      [qpw_pkg::NPOT-1:0]                  WIPER_TO_B_SHORT,
	output logic      [qpw_pkg::NPOT*TAPS-1:0]             TAP_SEL
);
	localparam int NP = qpw_pkg::NPOT;
	localparam int W = qpw_pkg::WIPER_W;
	localparam logic [W-1:0] FULL = W'(1 << WIPER_BITS);
	localparam logic [W-1:0] POR_W = W'(WIPER_POR);

	typedef struct packed {
		logic [NP-1:0][W-1:0]    wiper;
		logic [7:0]              tcon_hi;
		logic [NP-1:0]           lock;
		logic [W-1:0]            rdata;
		logic                    reject;
		logic                    nv_stb;
		logic [1:0]              nv_pot;
		logic [W-1:0]            nv_data;
		logic [NP-1:0]           a_sw;
		logic [NP-1:0]           w_sw;
		logic [NP-1:0]           b_sw;
		logic [NP-1:0]           wb_short;
		logic [NP-1:0][TAPS-1:0] tap;
	} qpw_state_t;

	qpw_state_t            st_r;
	qpw_state_t            st_nxt;
	logic [NP-1:0][TAPS-1:0] dec_tap;
	logic [W-1:0]          cur;
	logic                  locked;

	// ---------------------------------------------------------------
	// per network tap decoders
	// ---------------------------------------------------------------
	genvar g;
	for (g = 0; g < NP; g++) begin : g_net
		qpw_tap_if #(.TAPS(TAPS)) tif ();
		assign tif.wiper = st_r.wiper[g];
		assign dec_tap[g] = tif.tap;
		qpw_tap_decoder #(
			.WIPER_BITS (WIPER_BITS),
			.TAPS       (TAPS)
		) u_dec (
			.tif (tif)
		);
	end

	assign cur = st_r.wiper[CMD_POT];
	assign locked = st_r.lock[CMD_POT];

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0] nib;
		logic       shdn;
		nib = '0;
		shdn = 1'b0;
		st_nxt = st_r;
		st_nxt.reject = 1'b0;
		st_nxt.nv_stb = 1'b0;
		if (CMD_VALID) begin
			case (CMD_OP)
				qpw_pkg::OP_WR_WIPER: begin
					if (locked) begin
						st_nxt.reject = 1'b1;
					end else begin
						st_nxt.wiper[CMD_POT] = CMD_DATA;
					end
				end
				qpw_pkg::OP_INC: begin
					if (locked) begin
						st_nxt.reject = 1'b1;
					end else if (cur < FULL) begin
						st_nxt.wiper[CMD_POT] = cur + qpw_pkg::WIPER_STEP;
					end
				end
				qpw_pkg::OP_DEC: begin
					if (locked) begin
						st_nxt.reject = 1'b1;
					end else if (cur != qpw_pkg::WIPER_ZERO && cur <= FULL) begin
						st_nxt.wiper[CMD_POT] = cur - qpw_pkg::WIPER_STEP;
					end
				end
				qpw_pkg::OP_RD_WIPER: begin
					st_nxt.rdata = cur;
				end
				qpw_pkg::OP_WR_TCON: begin
					for (int j = 0; j < 2; j++) begin
						if (st_r.lock[2+j]) begin
							st_nxt.reject = 1'b1;
						end else begin
							st_nxt.tcon_hi[j*qpw_pkg::TC_NIB +: qpw_pkg::TC_NIB] =
								CMD_DATA[j*qpw_pkg::TC_NIB +: qpw_pkg::TC_NIB];
						end
					end
				end
				qpw_pkg::OP_RD_TCON: begin
					st_nxt.rdata = '0;
					st_nxt.rdata[qpw_pkg::TC_FIXED] = 1'b1;
					st_nxt.rdata[qpw_pkg::TC_HI_W-1:0] = st_r.tcon_hi;
				end
				qpw_pkg::OP_WR_NV: begin
					if (locked) begin
						st_nxt.reject = 1'b1;
					end else begin
						st_nxt.nv_stb = 1'b1;
						st_nxt.nv_pot = CMD_POT;
						st_nxt.nv_data = CMD_DATA;
					end
				end
				qpw_pkg::OP_HV_LOCK: begin
					if (HIGH_VOLTAGE_CMD_STROBE) begin
						st_nxt.lock[CMD_POT] = CMD_DATA[0];
					end else begin
						st_nxt.reject = 1'b1;
					end
				end
				default: begin
					st_nxt.reject = 1'b1;
				end
			endcase
		end
		// switches follow the committed registers, one cycle after a write
		for (int p = 0; p < NP; p++) begin
			if (p < 2) begin
				nib = TCON_LO[p*qpw_pkg::TC_NIB +: qpw_pkg::TC_NIB];
			end else begin
				nib = st_r.tcon_hi[(p-2)*qpw_pkg::TC_NIB +: qpw_pkg::TC_NIB];
			end
			shdn = !nib[qpw_pkg::TC_SHDN_N];
			st_nxt.a_sw[p] = nib[qpw_pkg::TC_A] && !shdn;
			st_nxt.w_sw[p] = nib[qpw_pkg::TC_W] && !shdn;
			st_nxt.b_sw[p] = nib[qpw_pkg::TC_B] && !shdn;
			st_nxt.wb_short[p] = shdn;
			st_nxt.tap[p] = dec_tap[p];
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			st_r <= '0;
			st_r.wiper <= {NP{POR_W}};
			st_r.tcon_hi <= qpw_pkg::TCON_RST[qpw_pkg::TC_HI_W-1:0];
			st_r.lock <= LOCK_INIT;
			st_r.a_sw <= '1;
			st_r.w_sw <= '1;
			st_r.b_sw <= '1;
			st_r.tap <= {NP{TAPS'(1) << WIPER_POR}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign CMD_RDATA = st_r.rdata;
	assign CMD_REJECT = st_r.reject;
	assign NV_WR_STB = st_r.nv_stb;
	assign NV_WR_POT = st_r.nv_pot;
	assign NV_WR_DATA = st_r.nv_data;
	assign LOCK_STAT = st_r.lock;
	assign END_A_CONNECT = st_r.a_sw;
	assign WIPER_CONNECT = st_r.w_sw;
	assign END_B_CONNECT = st_r.b_sw;
	assign WIPER_TO_B_SHORT = st_r.wb_short;
	assign TAP_SEL = st_r.tap;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	locked_wiper_hold_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_WIPER && locked
		|=> CMD_REJECT && st_r.wiper[$past(CMD_POT)] == $past(cur))
		else $error("locked wiper was written");
	dec_at_zero_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_DEC && !locked
		&& cur == qpw_pkg::WIPER_ZERO |=> st_r.wiper[$past(CMD_POT)] == qpw_pkg::WIPER_ZERO)
		else $error("decrement wrapped below zero");
	inc_at_full_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_INC && !locked
		&& cur == FULL |=> st_r.wiper[$past(CMD_POT)] == FULL)
		else $error("increment passed full scale");
	reserved_hold_a: assert property (CMD_VALID && (CMD_OP == qpw_pkg::OP_INC || CMD_OP == qpw_pkg::OP_DEC)
		&& cur > FULL |=> st_r.wiper[$past(CMD_POT)] == $past(cur))
		else $error("reserved wiper value moved");
	tcon_keeps_wiper_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_TCON
		|=> st_r.wiper == $past(st_r.wiper))
		else $error("terminal write changed a wiper");
	shutdown_pot3_a: assert property (!st_r.tcon_hi[7]
		|=> !END_A_CONNECT[3] && WIPER_TO_B_SHORT[3] && !WIPER_CONNECT[3])
		else $error("pot 3 shutdown not forced");
	connect_pot2_a: assert property (st_r.tcon_hi[3]
		|=> END_A_CONNECT[2] == $past(st_r.tcon_hi[2]) && END_B_CONNECT[2] == $past(st_r.tcon_hi[0]))
		else $error("pot 2 connect bits not followed");
	fixed_top_bit_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_RD_TCON
		|=> CMD_RDATA[qpw_pkg::TC_FIXED])
		else $error("upper terminal bit 8 read as zero");
	lock_hv_only_a: assert property ($changed(st_r.lock)
		|-> $past(HIGH_VOLTAGE_CMD_STROBE && CMD_VALID && CMD_OP == qpw_pkg::OP_HV_LOCK))
		else $error("lock changed without high voltage command");
	one_tap_a: assert property ($onehot(st_r.tap[0]) && $onehot(st_r.tap[3]))
		else $error("tap select not one-hot");
	full_decode_a: assert property (st_r.wiper[1] >= FULL |=> st_r.tap[1][TAPS-1])
		else $error("above full scale not decoded as terminal A");
	reset_tcon_a: assert property ($past(RST) |-> st_r.tcon_hi == qpw_pkg::TCON_RST[7:0])
		else $error("terminal register not all ones after reset");
	write_delay_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_TCON
		&& !st_r.lock[3] |=> ##1 END_A_CONNECT[3] == ($past(CMD_DATA[6], 2) && $past(CMD_DATA[7], 2)))
		else $error("terminal write did not reach pot 3 switch");
	shutdown_pot2_a: assert property (!st_r.tcon_hi[3]
		|=> !END_A_CONNECT[2] && !WIPER_CONNECT[2] && !END_B_CONNECT[2] && WIPER_TO_B_SHORT[2])
		else $error("pot 2 shutdown not forced");
	connect_pot3_a: assert property (st_r.tcon_hi[7]
		|=> END_A_CONNECT[3] == $past(st_r.tcon_hi[6]) && WIPER_CONNECT[3] == $past(st_r.tcon_hi[5])
		&& END_B_CONNECT[3] == $past(st_r.tcon_hi[4]) && !WIPER_TO_B_SHORT[3])
		else $error("pot 3 connect bits not followed");
	locked_nibble_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_TCON && st_r.lock[2]
		|=> CMD_REJECT && st_r.tcon_hi[3:0] == $past(st_r.tcon_hi[3:0]))
		else $error("locked pot 2 terminal bits were written");
	open_nibble_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_TCON && !st_r.lock[3]
		|=> st_r.tcon_hi[7:4] == $past(CMD_DATA[7:4]))
		else $error("unlocked pot 3 terminal bits not written");
	wiper_write_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_WIPER && !locked
		|=> st_r.wiper[$past(CMD_POT)] == $past(CMD_DATA))
		else $error("unlocked wiper write lost");
	inc_step_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_INC && !locked && cur < FULL
		|=> st_r.wiper[$past(CMD_POT)] == $past(cur) + qpw_pkg::WIPER_STEP)
		else $error("increment below full scale did not step");
	locked_nv_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_NV && locked
		|=> CMD_REJECT && !NV_WR_STB)
		else $error("locked nonvolatile write passed");
	hv_reject_a: assert property (CMD_VALID && CMD_OP == qpw_pkg::OP_HV_LOCK && !HIGH_VOLTAGE_CMD_STROBE
		|=> CMD_REJECT && st_r.lock == $past(st_r.lock))
		else $error("lock command without high voltage accepted");
	reject_pulse_a: assert property (CMD_REJECT && !CMD_VALID |=> !CMD_REJECT)
		else $error("reject held past one cycle");
	short_pot1_a: assert property (!TCON_LO[7] |=> WIPER_TO_B_SHORT[1] && !END_A_CONNECT[1])
		else $error("pot 1 shutdown not forced");
	one_tap_mid_a: assert property ($onehot(st_r.tap[1]) && $onehot(st_r.tap[2]))
		else $error("tap select not one-hot");

	// ---------------------------------------------------------------
	// coverage
	// ---------------------------------------------------------------
	inc_walk_c: cover property (CMD_VALID && CMD_OP == qpw_pkg::OP_INC && cur == FULL - qpw_pkg::WIPER_STEP);
	locked_tcon_c: cover property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_TCON && st_r.lock[2]);
	shutdown_exit_c: cover property (!st_r.tcon_hi[3] ##1 st_r.tcon_hi[3]);
	hv_lock_c: cover property (CMD_VALID && CMD_OP == qpw_pkg::OP_HV_LOCK && HIGH_VOLTAGE_CMD_STROBE);
	nv_write_c: cover property (CMD_VALID && CMD_OP == qpw_pkg::OP_WR_NV && !locked);
endmodule

// >>> src/qpw_pkg.sv
// Purpose: shared constants for the quad pot wiper and terminal control
// Assumes: command decoding of the serial link happens upstream
// Notes:   terminal nibble layout is the same for every network
package qpw_pkg;
	localparam int NPOT = 4;
	localparam int WIPER_W = 10;
	localparam int TC_NIB = 4;
	localparam int TC_HI_W = 8;
	localparam int TC_FIXED = 8;

	// bit positions inside one network's terminal nibble
	localparam int TC_SHDN_N = 3;
	localparam int TC_A = 2;
	localparam int TC_W = 1;
	localparam int TC_B = 0;

	localparam logic [8:0] TCON_RST = 9'h1FF;
	localparam logic [9:0] WIPER_ZERO = 10'h000;
	localparam logic [9:0] WIPER_STEP = 10'h001;

	// command codes
	localparam logic [2:0] OP_WR_WIPER = 3'h0;
	localparam logic [2:0] OP_INC = 3'h1;
	localparam logic [2:0] OP_DEC = 3'h2;
	localparam logic [2:0] OP_RD_WIPER = 3'h3;
	localparam logic [2:0] OP_WR_TCON = 3'h4;
	localparam logic [2:0] OP_RD_TCON = 3'h5;
	localparam logic [2:0] OP_WR_NV = 3'h6;
	localparam logic [2:0] OP_HV_LOCK = 3'h7;
endpackage

// >>> src/qpw_tap_if.sv
// Purpose: wiper value to tap select bundle for one network
// Assumes: one instance per network
// Notes:   dec side is the decoder, ctl side the controller
`timescale 1ns/1ps
interface qpw_tap_if #(
	parameter int TAPS = 257
);
	logic [qpw_pkg::WIPER_W-1:0] wiper;
	logic [TAPS-1:0]             tap;
	modport dec (input wiper, output tap);
	modport ctl (output wiper, input tap);
endinterface

// >>> src/qpw_tap_decoder.sv
// Purpose: one-of-N tap select for one resistor ladder
// Assumes: wiper value is stable for the cycle
// Notes:   values at or above full scale select terminal A
`timescale 1ns/1ps
module qpw_tap_decoder #(
	parameter int WIPER_BITS = 8,
	parameter int TAPS       = (1 << WIPER_BITS) + 1
) (
	qpw_tap_if.dec tif
);
	localparam logic [qpw_pkg::WIPER_W-1:0] FULL = qpw_pkg::WIPER_W'(1 << WIPER_BITS);

	logic sat;

	assign sat = (tif.wiper >= FULL);

	// ---------------------------------------------------------------
	// tap select, index 0 is terminal B, top index is terminal A
	// ---------------------------------------------------------------
	genvar i;
	for (i = 0; i < TAPS; i++) begin : g_tap
		localparam logic [qpw_pkg::WIPER_W-1:0] IDX = qpw_pkg::WIPER_W'(i);
		assign tif.tap[i] = sat ? (IDX == FULL) : (tif.wiper == IDX);
	end
endmodule

// >>> tb/qpw_host_model.sv
// Purpose: host controller issuing completed serial commands
// Assumes: one command per two clock cycles, driven on falling edges
// Notes:   released command lines show the inverse of the last value
`timescale 1ns/1ps
module qpw_host_model (
	input  wire logic       clk,
	output logic            cmd_valid,
	output logic [2:0]      cmd_op,
	output logic [1:0]      cmd_pot,
	output logic [9:0]      cmd_data,
	output logic            hv_strobe
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_pot = 2'h0;
		cmd_data = 10'h000;
		hv_strobe = 1'b0;
	end

	task automatic send(input logic [2:0] op, input logic [1:0] pot, input logic [9:0] data, input logic hv);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_pot = pot;
		cmd_data = data;
		hv_strobe = hv;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_op = ~op;
		cmd_pot = ~pot;
		cmd_data = ~data;
		hv_strobe = ~hv;
	endtask
endmodule

// >>> tb/qpw_top_tb.sv
// Purpose: self-checking bench for the quad pot control
// Assumes: 8-bit variant, full scale 10'h100, 257 taps; a 7-bit twin checks its full-scale end and a reserved value above it
// Notes:   expected values come from the terminal and wiper maps
`timescale 1ns/1ps
module qpw_top_tb;
	localparam int TAPS = 257;
	localparam int TAPS7 = 129;
	logic                  ref_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  cmd_valid;
	logic [2:0]            cmd_op;
	logic [1:0]            cmd_pot;
	logic [9:0]            cmd_data;
	logic                  hv_strobe;
	logic [9:0]            cmd_rdata;
	logic                  cmd_reject;
	logic [3:0]            lock_stat;
	logic [3:0]            end_a;
	logic [3:0]            wip_c;
	logic [3:0]            end_b;
	logic [3:0]            short_wb;
	logic [4*TAPS-1:0]     tap_sel;
	logic                  nv_stb;
	logic [1:0]            nv_pot;
	logic [9:0]            nv_data;
	logic [9:0]            rdata7;
	logic [4*TAPS7-1:0]    tap7;
	logic [3:0]            lock_init = 4'h0;
	logic [7:0]            tcon_lo = 8'hFF;
	int                    num_errors = 0;
	int                    checked = 0;

	always #10 ref_clk = ~ref_clk;

	qpw_host_model i_host (.clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_pot(cmd_pot),
		.cmd_data(cmd_data), .hv_strobe(hv_strobe));

	qpw_top #(.WIPER_BITS(8)) i_dut (.REF_CLK(ref_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_POT(cmd_pot), .CMD_DATA(cmd_data), .HIGH_VOLTAGE_CMD_STROBE(hv_strobe), .LOCK_INIT(lock_init),
		.TCON_LO(tcon_lo), .CMD_RDATA(cmd_rdata), .CMD_REJECT(cmd_reject), .NV_WR_STB(nv_stb),
		.NV_WR_POT(nv_pot), .NV_WR_DATA(nv_data), .LOCK_STAT(lock_stat), .END_A_CONNECT(end_a),
		.WIPER_CONNECT(wip_c), .END_B_CONNECT(end_b), .WIPER_TO_B_SHORT(short_wb), .TAP_SEL(tap_sel));

	qpw_top #(.WIPER_BITS(7)) i_dut7 (.REF_CLK(ref_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_POT(cmd_pot), .CMD_DATA(cmd_data), .HIGH_VOLTAGE_CMD_STROBE(hv_strobe), .LOCK_INIT(4'h0),
		.TCON_LO(8'hFF), .CMD_RDATA(rdata7), .CMD_REJECT(), .NV_WR_STB(), .NV_WR_POT(), .NV_WR_DATA(),
		.LOCK_STAT(), .END_A_CONNECT(), .WIPER_CONNECT(), .END_B_CONNECT(), .WIPER_TO_B_SHORT(), .TAP_SEL(tap7));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// order of bits: a, w, b, short
	task automatic chk_sw(input int p, input logic [3:0] e);
		chk({12'h000, end_a[p], wip_c[p], end_b[p], short_wb[p]}, {12'h000, e});
	endtask

	task automatic chk_tap(input int p, input int idx);
		logic [TAPS-1:0] e;
		e = '0;
		e[idx] = 1'b1;
		chk({15'h0000, tap_sel[p*TAPS +: TAPS] === e}, 16'h0001);
	endtask

	task automatic chk_tap7(input int p, input int idx);
		logic [TAPS7-1:0] e;
		e = '0;
		e[idx] = 1'b1;
		chk({15'h0000, tap7[p*TAPS7 +: TAPS7] === e}, 16'h0001);
	endtask

	task automatic rd(input logic [2:0] op, input logic [1:0] p, input logic [9:0] e);
		i_host.send(op, p, 10'h000, 1'b0);
		chk({6'h00, cmd_rdata}, {6'h00, e});
	endtask

	task automatic t_reset();
		rd(qpw_pkg::OP_RD_TCON, 2'h0, 10'h1FF);
		chk_sw(2, 4'hE);
		chk_sw(3, 4'hE);
		for (int p = 0; p < 4; p++) begin
			chk_tap(p, 128);
		end
	endtask

	task automatic t_tcon();
		logic [9:0] d [3] = '{10'h07F, 10'h0A5, 10'h0DA};
		logic [3:0] e3 [3] = '{4'h1, 4'h4, 4'hA};
		logic [3:0] e2 [3] = '{4'hE, 4'h1, 4'h4};
		for (int i = 0; i < 3; i++) begin
			i_host.send(qpw_pkg::OP_WR_TCON, 2'h1, d[i], 1'b0);
			if (i == 0) chk_sw(3, 4'hE);
			@(negedge ref_clk);
			chk_sw(3, e3[i]);
			chk_sw(2, e2[i]);
			rd(qpw_pkg::OP_RD_TCON, 2'h0, d[i] | 10'h100);
		end
		rd(qpw_pkg::OP_RD_WIPER, 2'h3, 10'h080);
	endtask

	task automatic t_wiper();
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h1, 10'h000, 1'b0);
		i_host.send(qpw_pkg::OP_DEC, 2'h1, 10'h000, 1'b0);
		rd(qpw_pkg::OP_RD_WIPER, 2'h1, 10'h000);
		chk_tap(1, 0);
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h1, 10'h0FF, 1'b0);
		i_host.send(qpw_pkg::OP_INC, 2'h1, 10'h000, 1'b0);
		i_host.send(qpw_pkg::OP_INC, 2'h1, 10'h000, 1'b0);
		rd(qpw_pkg::OP_RD_WIPER, 2'h1, 10'h100);
		chk_tap(1, 256);
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h1, 10'h101, 1'b0);
		i_host.send(qpw_pkg::OP_INC, 2'h1, 10'h000, 1'b0);
		i_host.send(qpw_pkg::OP_DEC, 2'h1, 10'h000, 1'b0);
		rd(qpw_pkg::OP_RD_WIPER, 2'h1, 10'h101);
		chk_tap(1, 256);
		chk_tap(0, 128);
	endtask

	task automatic t_lock();
		i_host.send(qpw_pkg::OP_HV_LOCK, 2'h2, 10'h001, 1'b0);
		chk({15'h0000, cmd_reject}, 16'h0001);
		chk({12'h000, lock_stat}, 16'h0000);
		i_host.send(qpw_pkg::OP_HV_LOCK, 2'h2, 10'h001, 1'b1);
		chk({12'h000, lock_stat}, 16'h0004);
		i_host.send(qpw_pkg::OP_WR_TCON, 2'h0, 10'h000, 1'b0);
		chk({15'h0000, cmd_reject}, 16'h0001);
		rd(qpw_pkg::OP_RD_TCON, 2'h0, 10'h10A);
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h2, 10'h010, 1'b0);
		chk({15'h0000, cmd_reject}, 16'h0001);
		rd(qpw_pkg::OP_RD_WIPER, 2'h2, 10'h080);
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h3, 10'h010, 1'b0);
		chk({15'h0000, cmd_reject}, 16'h0000);
		rd(qpw_pkg::OP_RD_WIPER, 2'h3, 10'h010);
	endtask

	task automatic t_wiper7();
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h0, 10'h07F, 1'b0);
		i_host.send(qpw_pkg::OP_INC, 2'h0, 10'h000, 1'b0);
		i_host.send(qpw_pkg::OP_INC, 2'h0, 10'h000, 1'b0);
		rd(qpw_pkg::OP_RD_WIPER, 2'h0, 10'h081);
		chk({6'h00, rdata7}, {6'h00, 10'h080});
		chk_tap7(0, 128);
		chk_tap(0, 129);
		i_host.send(qpw_pkg::OP_WR_WIPER, 2'h0, 10'h081, 1'b0);
		i_host.send(qpw_pkg::OP_DEC, 2'h0, 10'h000, 1'b0);
		rd(qpw_pkg::OP_RD_WIPER, 2'h0, 10'h080);
		chk({6'h00, rdata7}, {6'h00, 10'h081});
		chk_tap7(0, 128);
	endtask

	task automatic t_nv();
		i_host.send(qpw_pkg::OP_WR_NV, 2'h3, 10'h2A5, 1'b0);
		chk({15'h0000, nv_stb}, 16'h0001);
		chk({4'h0, nv_pot, nv_data}, {4'h0, 2'h3, 10'h2A5});
		i_host.send(qpw_pkg::OP_WR_NV, 2'h2, 10'h15A, 1'b0);
		chk({14'h0000, nv_stb, cmd_reject}, 16'h0001);
		chk({4'h0, nv_pot, nv_data}, {4'h0, 2'h3, 10'h2A5});
	endtask

	task automatic t_lower();
		@(negedge ref_clk);
		tcon_lo = 8'h7A;
		repeat (2) @(negedge ref_clk);
		chk_sw(0, 4'h4);
		chk_sw(1, 4'h1);
	endtask

	task automatic t_reset2();
		@(negedge ref_clk);
		lock_init = 4'h9;
		rst = 1'b1;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		chk({12'h000, lock_stat}, 16'h0009);
		chk_sw(3, 4'hE);
		rd(qpw_pkg::OP_RD_TCON, 2'h0, 10'h1FF);
	endtask

	task automatic complete_run();
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_tcon();
		t_wiper();
		t_wiper7();
		t_lock();
		t_nv();
		t_lower();
		t_reset2();
		complete_run();
	end

	// watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		complete_run();
	end
endmodule
